// ==== rtl/bgc_regs.sv ====
/*
 * Parameter register bank of a 2D blit engine: line stride, rectangle
 * width and height, background/key and foreground colors, addressing
 * mode and color format, with a rectangle address walker that uses them.
 * Assumes a classic Wishbone master on CLK and a blit engine on CLK that
 * pulses PIX_ADV once per word consumed.
 */
// The implementer's own choice: register access over Wishbone.
// Function
// - Eleven-bit line stride in two byte registers
// - Stride used only for rectangular addressing
// - Stride never reaches display fetch paths
// - Width field ten bits, count minus one
// - Height field ten bits, count minus one
// - Background color for zero expansion bits
// - Background color doubles as transparency key
// - Foreground color for one bits, solid fill
// - Format bit selects sixteen or low eight bits
// - Rectangular when both linear selects are zero
`timescale 1ns/10ps
`include "bgc_params.svh"

module bgc_regs (
    input  wire logic               CLK,           // 200 MHz clock
    input  wire logic               RESET,         // Sync reset, active high
    input  wire logic               CE,            // Clock enable
    input  wire logic               WB_CYC_I,      // Bus cycle
    input  wire logic               WB_STB_I,      // Strobe
    input  wire logic               WB_WE_I,       // Write enable
    input  wire logic [11:0]        WB_ADR_I,      // Byte address
    input  wire logic [3:0]         WB_SEL_I,      // Byte lanes
    input  wire logic [31:0]        WB_DAT_I,      // Write data
    output logic      [31:0]        WB_DAT_O,      // Read data
    output logic                    WB_ACK_O,      // Acknowledge
    input  wire logic               PIX_ADV,       // Engine took one word
    output logic                    BLT_RECT,      // Rectangular addressing
    output logic                    BLT_16BPP,     // 16 bpp format
    output bgc_pkg::bgc_stride_t    BLT_STRIDE,    // Effective stride
    output bgc_pkg::bgc_dim_t       BLT_WIDTH,     // Width minus one
    output bgc_pkg::bgc_dim_t       BLT_HEIGHT,    // Height minus one
    output bgc_pkg::bgc_color_t     BLT_BG_COLOR,  // Zero-bit color
    output bgc_pkg::bgc_color_t     BLT_KEY_COLOR, // Transparency key
    output bgc_pkg::bgc_color_t     BLT_FG_COLOR,  // One-bit and fill color
    output logic                    WALK_BUSY,     // Walk in progress
    output bgc_pkg::bgc_addr_t      WALK_ADDR,     // Word offset of walk
    output bgc_pkg::bgc_dim_t       WALK_LINE,     // Current line
    output logic                    WALK_LAST      // Last word of rectangle
);
    import bgc_pkg::*;

    // Software-visible state
    logic        dst_lin;
    logic        src_lin;
    logic        fmt_16;
    bgc_stride_t stride;
    bgc_dim_t    width;
    bgc_dim_t    height;
    bgc_color_t  bg_color;
    bgc_color_t  fg_color;

    // Bus decode
    logic        bus_req;
    logic        bus_wr;
    logic [9:0]  idx;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic        start_req;

    // Walker
    bgc_walk_t   walk_state;
    bgc_addr_t   line_base;
    bgc_addr_t   next_base;
    bgc_words_t  col;
    bgc_words_t  line_words;
    logic        rect;
    logic        line_end;
    logic        rect_end;

    // Keep only the lanes that the format uses
    function automatic bgc_color_t fmt_color(input logic wide, input bgc_color_t c);
        bgc_color_t r;
        r = c;
        if (!wide) begin
            r[15:8] = 8'h00;
        end
        return r;
    endfunction

    // Words per line; 8 bpp packs two pixels, phase zero assumed
    function automatic bgc_words_t words_per_line(input logic wide, input bgc_dim_t w);
        bgc_words_t n;
        n = {1'b0, w} + 11'h001;
        if (!wide) begin
            n = ({1'b0, w} + 11'h002) >> 1;
        end
        return n;
    endfunction

    assign bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign idx       = WB_ADR_I[11:2];
    assign wbyte     = WB_DAT_I[7:0];
    // Writes land only through lane zero; other lanes carry no register bits
    assign bus_wr    = bus_req & WB_WE_I & WB_SEL_I[0];
    assign start_req = bus_wr && (idx == `BGC_IDX_CTRL) && wbyte[`BGC_CTRL_START];

    assign rect       = ~dst_lin & ~src_lin;
    assign line_words = words_per_line(fmt_16, width);
    assign line_end   = (col == line_words - 11'h001);
    assign rect_end   = line_end && (WALK_LINE == height);

    // Single-cycle classic answer: ack one edge after the request
    always_ff @(posedge CLK) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
        end else if (CE) begin
            WB_ACK_O <= bus_req;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            dst_lin <= 1'b0;
            src_lin <= 1'b0;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_CTRL) begin
                dst_lin <= wbyte[`BGC_CTRL_DST_LIN];
                src_lin <= wbyte[`BGC_CTRL_SRC_LIN];
            end
        end
    end

    // Format bit also masks the color outputs
    always_ff @(posedge CLK) begin
        if (RESET) begin
            fmt_16 <= 1'b0;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_FMT) begin
                fmt_16 <= wbyte[`BGC_FMT_16BPP];
            end
        end
    end

    // Stride: low byte whole, high byte keeps bits 2-0 only
    always_ff @(posedge CLK) begin
        if (RESET) begin
            stride <= `BGC_RST_STRIDE;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_STRIDE_LO) begin
                stride[7:0] <= wbyte;
            end
            if (idx == `BGC_IDX_STRIDE_HI) begin
                stride[10:8] <= wbyte[2:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            width <= `BGC_RST_DIM;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_WIDTH_LO) begin
                width[7:0] <= wbyte;
            end
            if (idx == `BGC_IDX_WIDTH_HI) begin
                width[9:8] <= wbyte[1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            height <= `BGC_RST_DIM;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_HEIGHT_LO) begin
                height[7:0] <= wbyte;
            end
            if (idx == `BGC_IDX_HEIGHT_HI) begin
                height[9:8] <= wbyte[1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            bg_color <= `BGC_RST_COLOR;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_BG_LO) begin
                bg_color[7:0] <= wbyte;
            end
            if (idx == `BGC_IDX_BG_HI) begin
                bg_color[15:8] <= wbyte;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            fg_color <= `BGC_RST_COLOR;
        end else if (CE && bus_wr) begin
            if (idx == `BGC_IDX_FG_LO) begin
                fg_color[7:0] <= wbyte;
            end
            if (idx == `BGC_IDX_FG_HI) begin
                fg_color[15:8] <= wbyte;
            end
        end
    end

    // Read mux; unmapped indices answer zero
    always_comb begin
        case (idx)
            `BGC_IDX_CTRL: begin
                rbyte = {WALK_BUSY, 5'h00, src_lin, dst_lin};
            end
            `BGC_IDX_FMT: begin
                rbyte = {7'h00, fmt_16};
            end
            `BGC_IDX_STRIDE_LO: begin
                rbyte = stride[7:0];
            end
            `BGC_IDX_STRIDE_HI: begin
                rbyte = {5'h00, stride[10:8]};
            end
            `BGC_IDX_WIDTH_LO: begin
                rbyte = width[7:0];
            end
            `BGC_IDX_WIDTH_HI: begin
                rbyte = {6'h00, width[9:8]};
            end
            `BGC_IDX_HEIGHT_LO: begin
                rbyte = height[7:0];
            end
            `BGC_IDX_HEIGHT_HI: begin
                rbyte = {6'h00, height[9:8]};
            end
            `BGC_IDX_BG_LO: begin
                rbyte = bg_color[7:0];
            end
            `BGC_IDX_BG_HI: begin
                rbyte = bg_color[15:8];
            end
            `BGC_IDX_FG_LO: begin
                rbyte = fg_color[7:0];
            end
            `BGC_IDX_FG_HI: begin
                rbyte = fg_color[15:8];
            end
            `BGC_IDX_LINE_LO: begin
                rbyte = WALK_LINE[7:0];
            end
            `BGC_IDX_LINE_HI: begin
                rbyte = {6'h00, WALK_LINE[9:8]};
            end
            default: begin
                rbyte = `BGC_RST_BYTE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            WB_DAT_O <= `BGC_RST_DATA;
        end else if (CE && bus_req) begin
            WB_DAT_O <= {24'h000000, rbyte};
        end
    end

    // Parameters to the engine, registered; stride also feeds the walker's line step
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BLT_RECT   <= 1'b0;
            BLT_16BPP  <= 1'b0;
            BLT_STRIDE <= `BGC_RST_STRIDE;
            BLT_WIDTH  <= `BGC_RST_DIM;
            BLT_HEIGHT <= `BGC_RST_DIM;
        end else if (CE) begin
            BLT_RECT   <= rect;
            BLT_16BPP  <= fmt_16;
            BLT_STRIDE <= rect ? stride : `BGC_RST_STRIDE;
            BLT_WIDTH  <= width;
            BLT_HEIGHT <= height;
        end
    end

    // Masked here so the engine never sees a stale high byte in 8 bpp
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BLT_BG_COLOR  <= `BGC_RST_COLOR;
            BLT_KEY_COLOR <= `BGC_RST_COLOR;
            BLT_FG_COLOR  <= `BGC_RST_COLOR;
        end else if (CE) begin
            BLT_BG_COLOR  <= fmt_color(fmt_16, bg_color);
            BLT_KEY_COLOR <= fmt_color(fmt_16, bg_color);
            BLT_FG_COLOR  <= fmt_color(fmt_16, fg_color);
        end
    end

    bgc_line_step u_line_step (
        .rect      (rect),
        .stride    (stride),
        .words     (line_words),
        .base      (line_base),
        .next_base (next_base)
    );

    // Rectangle walk; a start while busy is ignored
    always_ff @(posedge CLK) begin
        if (RESET) begin
            walk_state <= BGC_IDLE;
            line_base  <= `BGC_RST_ADDR;
            WALK_ADDR  <= `BGC_RST_ADDR;
            WALK_LINE  <= `BGC_RST_DIM;
            col        <= `BGC_RST_COL;
        end else if (CE) begin
            case (walk_state)
                BGC_IDLE: begin
                    if (start_req) begin
                        walk_state <= BGC_RUN;
                        line_base  <= `BGC_RST_ADDR;
                        WALK_ADDR  <= `BGC_RST_ADDR;
                        WALK_LINE  <= `BGC_RST_DIM;
                        col        <= 11'h000;
                    end
                end
                BGC_RUN: begin
                    if (PIX_ADV) begin
                        if (rect_end) begin
                            walk_state <= BGC_IDLE;
                        end else if (line_end) begin
                            line_base <= next_base;
                            WALK_ADDR <= next_base;
                            WALK_LINE <= WALK_LINE + 10'h001;
                            col       <= 11'h000;
                        end else begin
                            WALK_ADDR <= WALK_ADDR + 21'h000001;
                            col       <= col + 11'h001;
                        end
                    end
                end
                default: begin
                    walk_state <= BGC_IDLE;
                end
            endcase
        end
    end

    assign WALK_BUSY = (walk_state == BGC_RUN);
    assign WALK_LAST = WALK_BUSY & rect_end;
endmodule

// ==== rtl/bgc_params.svh ====
/*
 * Constants of the blit geometry and color register bank: register
 * indices, field positions, reset values and bus figures.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef BGC_PARAMS_SVH
`define BGC_PARAMS_SVH

// Register indices; byte address is four times the index
`define BGC_IDX_CTRL      10'h100
`define BGC_IDX_FMT       10'h101
`define BGC_IDX_STRIDE_LO 10'h10C
`define BGC_IDX_STRIDE_HI 10'h10D
`define BGC_IDX_WIDTH_LO  10'h110
`define BGC_IDX_WIDTH_HI  10'h111
`define BGC_IDX_HEIGHT_LO 10'h112
`define BGC_IDX_HEIGHT_HI 10'h113
`define BGC_IDX_BG_LO     10'h114
`define BGC_IDX_BG_HI     10'h115
`define BGC_IDX_FG_LO     10'h118
`define BGC_IDX_FG_HI     10'h119
`define BGC_IDX_LINE_LO   10'h11C
`define BGC_IDX_LINE_HI   10'h11D

// Field positions
`define BGC_CTRL_DST_LIN  0
`define BGC_CTRL_SRC_LIN  1
`define BGC_CTRL_START    7
`define BGC_FMT_16BPP     0

// Reset values
`define BGC_RST_BYTE      8'h00
`define BGC_RST_LIN       2'h0
`define BGC_RST_STRIDE    11'h000
`define BGC_RST_DIM       10'h000
`define BGC_RST_COLOR     16'h0000
`define BGC_RST_ADDR      21'h000000
`define BGC_RST_DATA      32'h00000000
`define BGC_RST_COL       11'h000

`endif

// ==== rtl/bgc_pkg.sv ====
/*
 * Types of the blit geometry and color register bank.
 * Assumes bgc_params.svh is on the include path.
 */
package bgc_pkg;
    typedef logic [15:0] bgc_color_t;
    typedef logic [10:0] bgc_stride_t;
    typedef logic [9:0]  bgc_dim_t;
    typedef logic [20:0] bgc_addr_t;
    typedef logic [10:0] bgc_words_t;
    typedef enum logic {BGC_IDLE, BGC_RUN} bgc_walk_t;
endpackage

// ==== rtl/bgc_line_step.sv ====
/*
 * Next line base address of the blit rectangle walk.
 * Assumes all inputs derive from registered values on the caller's clock.
 */
`timescale 1ns/10ps
`include "bgc_params.svh"

module bgc_line_step (
    input  wire logic                 rect,      // Rectangular addressing selected
    input  wire bgc_pkg::bgc_stride_t stride,    // Line stride in words
    input  wire bgc_pkg::bgc_words_t  words,     // Words in one line
    input  wire bgc_pkg::bgc_addr_t   base,      // Current line base
    output bgc_pkg::bgc_addr_t        next_base  // Next line base
);
    import bgc_pkg::*;

    bgc_addr_t step;

    always_comb begin
        // Linear lines follow one another directly
        if (rect) begin
            step = {10'h000, stride};
        end else begin
            step = {10'h000, words};
        end
        next_base = base + step;
    end
endmodule

// ==== dv/bgc_regs_assertions.sv ====
/*
 * Port checker for the blit geometry and color register bank.
 * Assumes one CLK domain and a bind onto bgc_regs.
 */
`timescale 1ns/10ps

module bgc_regs_assertions (
    input wire logic                 CLK,           // Clock
    input wire logic                 RESET,         // Sync reset
    input wire logic                 CE,            // Clock enable
    input wire logic                 WB_CYC_I,      // Bus cycle
    input wire logic                 WB_STB_I,      // Strobe
    input wire logic                 WB_WE_I,       // Write enable
    input wire logic [11:0]          WB_ADR_I,      // Byte address
    input wire logic [3:0]           WB_SEL_I,      // Byte lanes
    input wire logic [31:0]          WB_DAT_I,      // Write data
    input wire logic [31:0]          WB_DAT_O,      // Read data
    input wire logic                 WB_ACK_O,      // Acknowledge
    input wire logic                 PIX_ADV,       // Word taken
    input wire logic                 BLT_RECT,      // Rectangular mode
    input wire logic                 BLT_16BPP,     // Format
    input wire bgc_pkg::bgc_stride_t BLT_STRIDE,    // Stride
    input wire bgc_pkg::bgc_dim_t    BLT_WIDTH,     // Width
    input wire bgc_pkg::bgc_dim_t    BLT_HEIGHT,    // Height
    input wire bgc_pkg::bgc_color_t  BLT_BG_COLOR,  // Background
    input wire bgc_pkg::bgc_color_t  BLT_KEY_COLOR, // Key
    input wire bgc_pkg::bgc_color_t  BLT_FG_COLOR,  // Foreground
    input wire logic                 WALK_BUSY,     // Walk busy
    input wire bgc_pkg::bgc_addr_t   WALK_ADDR,     // Walk offset
    input wire bgc_pkg::bgc_dim_t    WALK_LINE,     // Walk line
    input wire logic                 WALK_LAST      // Last word
);
    logic req;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    a_ack_answer: assert property (req |=> WB_ACK_O) else $error("request not acked");
    a_ack_single: assert property (WB_ACK_O && CE |=> !WB_ACK_O) else $error("ack too long");
    a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000) else $error("upper read bits");
    a_key_is_bg: assert property (BLT_KEY_COLOR == BLT_BG_COLOR) else $error("key differs from bg");
    a_color_low_only: assert property (!BLT_16BPP |-> BLT_BG_COLOR[15:8] == 8'h00 && BLT_FG_COLOR[15:8] == 8'h00)
        else $error("high color byte in 8 bpp");
    a_stride_rect_only: assert property (!BLT_RECT |-> BLT_STRIDE == 11'h000) else $error("stride in linear");
    // Three idle bus cycles cover the one-cycle output lag
    a_geom_holds: assert property (!(WB_CYC_I && WB_STB_I) [*3] |-> $stable(BLT_WIDTH) && $stable(BLT_HEIGHT))
        else $error("geometry changed without write");
    a_walk_start: assert property (req && WB_WE_I && WB_SEL_I[0] && WB_DAT_I[7] && WB_ADR_I[11:2] == 10'h100
        && !WALK_BUSY |=> WALK_BUSY && WALK_ADDR == 21'h000000) else $error("walk did not start");
    a_walk_waits: assert property (WALK_BUSY && !PIX_ADV && CE |=> WALK_BUSY && $stable(WALK_ADDR))
        else $error("walk moved without word");
    a_walk_end: assert property (WALK_BUSY && WALK_LAST && PIX_ADV && CE |=> !WALK_BUSY)
        else $error("walk did not end");
    a_ce_freeze: assert property (!CE |=> $stable(WB_ACK_O) && $stable(WALK_ADDR) && $stable(WALK_LINE)
        && $stable(WALK_BUSY)) else $error("state moved while CE low");

    c_walk_end: cover property (WALK_BUSY && WALK_LAST && PIX_ADV);
    c_rect_stride: cover property (BLT_RECT && BLT_STRIDE != 11'h000);
    c_low_color: cover property (!BLT_16BPP && BLT_FG_COLOR != 16'h0000);
    c_ce_walk: cover property (!CE && WALK_BUSY && PIX_ADV);
endmodule

bind bgc_regs bgc_regs_assertions chk_u (.CLK, .RESET, .CE, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .PIX_ADV, .BLT_RECT, .BLT_16BPP, .BLT_STRIDE, .BLT_WIDTH,
    .BLT_HEIGHT, .BLT_BG_COLOR, .BLT_KEY_COLOR, .BLT_FG_COLOR, .WALK_BUSY, .WALK_ADDR, .WALK_LINE, .WALK_LAST);

// ==== dv/tb_bgc_regs.sv ====
/*
 * Self-checking bench for the blit register bank: readback, outputs, walks.
 * Assumes bgc_params.svh on the include path; CE drops only inside walks.
 */
`timescale 1ns/10ps
`include "bgc_params.svh"

module tb_bgc_regs;
    import bgc_pkg::*;
    logic        CLK, RESET, CE, cyc, stb, we, pix, ack, rect, bpp16, busy, last;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat, q, dout, seed;
    bgc_stride_t stride;
    bgc_dim_t    width, height, wline;
    bgc_color_t  bg, key, fg;
    bgc_addr_t   waddr;
    logic [7:0]  sh [logic [9:0]];
    logic [9:0]  ids [13];
    int          mismatches, tests_run, cycles;

    bgc_regs dut_u (.CLK(CLK), .RESET(RESET), .CE(CE), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .PIX_ADV(pix),
        .BLT_RECT(rect), .BLT_16BPP(bpp16), .BLT_STRIDE(stride), .BLT_WIDTH(width), .BLT_HEIGHT(height),
        .BLT_BG_COLOR(bg), .BLT_KEY_COLOR(key), .BLT_FG_COLOR(fg), .WALK_BUSY(busy), .WALK_ADDR(waddr),
        .WALK_LINE(wline), .WALK_LAST(last));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Implemented bits of each byte register; unmapped places hold nothing
    function logic [7:0] msk(input logic [9:0] i);
        case (i)
            `BGC_IDX_CTRL: return 8'h03;
            `BGC_IDX_FMT: return 8'h01;
            `BGC_IDX_STRIDE_HI: return 8'h07;
            `BGC_IDX_WIDTH_HI, `BGC_IDX_HEIGHT_HI: return 8'h03;
            `BGC_IDX_STRIDE_LO, `BGC_IDX_WIDTH_LO, `BGC_IDX_HEIGHT_LO, `BGC_IDX_BG_LO, `BGC_IDX_BG_HI,
            `BGC_IDX_FG_LO, `BGC_IDX_FG_HI: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic [9:0] i, input logic w, input logic [7:0] d, input logic [3:0] s);
        int n;
        logic [31:0] r;
        r = rnd();
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {i, r[1:0]};
        sel <= s;
        dat <= {r[31:8], d};
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            $display("[FAIL] %0t no ack", $time);
        end
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [3:0] s);
        bus(i, 1'b1, d, s);
        if (s[0]) sh[i] = d & msk(i);
    endtask

    task automatic outs();
        logic f, r;
        repeat (2) @(posedge CLK);
        f = sh[`BGC_IDX_FMT][0];
        r = sh[`BGC_IDX_CTRL][1:0] == 2'b00;
        check(rect, r, "rect");
        check(bpp16, f, "format");
        check(stride, r ? {sh[`BGC_IDX_STRIDE_HI][2:0], sh[`BGC_IDX_STRIDE_LO]} : 11'h000, "stride");
        check(width, {sh[`BGC_IDX_WIDTH_HI][1:0], sh[`BGC_IDX_WIDTH_LO]}, "width");
        check(height, {sh[`BGC_IDX_HEIGHT_HI][1:0], sh[`BGC_IDX_HEIGHT_LO]}, "height");
        check(bg, {f ? sh[`BGC_IDX_BG_HI] : 8'h00, sh[`BGC_IDX_BG_LO]}, "bg");
        check(key, {f ? sh[`BGC_IDX_BG_HI] : 8'h00, sh[`BGC_IDX_BG_LO]}, "key");
        check(fg, {f ? sh[`BGC_IDX_FG_HI] : 8'h00, sh[`BGC_IDX_FG_LO]}, "fg");
    endtask

    // Geometry kept small so each walk stays short; stride is in words
    task automatic walk(input logic f, input logic [1:0] ls, input logic [10:0] st, input logic [2:0] w,
                        input logic [1:0] h);
        int base, col, ln, words;
        logic [31:0] r;
        wr(`BGC_IDX_FMT, {7'h00, f}, 4'hF);
        wr(`BGC_IDX_CTRL, {6'h00, ls}, 4'hF);
        wr(`BGC_IDX_STRIDE_LO, st[7:0], 4'hF);
        wr(`BGC_IDX_STRIDE_HI, {5'h00, st[10:8]}, 4'hF);
        wr(`BGC_IDX_WIDTH_LO, {5'h00, w}, 4'hF);
        wr(`BGC_IDX_WIDTH_HI, 8'h00, 4'hF);
        wr(`BGC_IDX_HEIGHT_LO, {6'h00, h}, 4'hF);
        wr(`BGC_IDX_HEIGHT_HI, 8'h00, 4'hF);
        outs();
        words = f ? w + 1 : (w + 2) >> 1;
        base = 0;
        col = 0;
        ln = 0;
        wr(`BGC_IDX_CTRL, {6'h20, ls}, 4'hF);
        bus(`BGC_IDX_CTRL, 1'b0, 8'h00, 4'hF);
        check(q, {24'h000000, 6'h20, ls}, "busy bit");
        // CE drops at random; a word counts only when both are high
        while (ln >= 0) begin
            r = rnd();
            pix <= r[0];
            CE  <= r[1] | r[2];
            @(posedge CLK);
            check(busy, 1'b1, "busy");
            check(waddr, base + col, "walk addr");
            check(wline, ln, "walk line");
            check(last, ln == h && col == words - 1, "last");
            if (pix === 1'b1 && CE === 1'b1) begin
                if (ln == h && col == words - 1) ln = -1;
                else if (col == words - 1) begin
                    col = 0;
                    ln++;
                    base += (ls == 2'b00) ? st : words;
                end
                else col++;
            end
        end
        pix <= 1'b0;
        CE  <= 1'b1;
        @(posedge CLK);
        check(busy, 1'b0, "idle");
        bus(`BGC_IDX_LINE_LO, 1'b0, 8'h00, 4'hF);
        check(q, {30'h00000000, h}, "line readback");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end

    initial begin
        logic [31:0] r;
        logic [7:0] d;
        seed = 69;
        {RESET, CE, cyc, stb, we, pix, adr, sel, dat} = {2'b11, 4'h0, 12'h000, 4'h0, 32'h0};
        ids = '{`BGC_IDX_CTRL, `BGC_IDX_FMT, `BGC_IDX_STRIDE_LO, `BGC_IDX_STRIDE_HI, `BGC_IDX_WIDTH_LO,
                `BGC_IDX_WIDTH_HI, `BGC_IDX_HEIGHT_LO, `BGC_IDX_HEIGHT_HI, `BGC_IDX_BG_LO, `BGC_IDX_BG_HI,
                `BGC_IDX_FG_LO, `BGC_IDX_FG_HI, 10'h3FF};
        foreach (ids[j]) sh[ids[j]] = 8'h00;
        repeat (3) @(posedge CLK);
        RESET <= 1'b0;
        // Round 0 reads reset values, rounds 1 and 2 all ones and zeros, then random
        for (int k = 0; k < 9; k++) begin
            foreach (ids[j]) begin
                r = rnd();
                d = (k == 1) ? 8'hFF : (k == 2) ? 8'h00 : r[7:0];
                if (k > 0) wr(ids[j], (ids[j] == `BGC_IDX_CTRL) ? d & 8'h7F : d, (k < 3) ? 4'hF : r[11:8]);
            end
            foreach (ids[j]) begin
                bus(ids[j], 1'b0, 8'h00, 4'hF);
                check(q, {24'h000000, sh[ids[j]]}, "readback");
            end
            outs();
        end
        walk(1'b1, 2'b00, 11'h008, 3'h1, 2'h1);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            walk(r[0], r[2:1], r[13:3], r[16:14], r[18:17]);
        end
        wrap_up();
    end
endmodule
